/* design/srt_ctl_if.sv */
// Carrier between the top and its sequencer and transmit gate
`timescale 1ns/100ps
interface srt_ctl_if;
    import srt_pkg::*;
    logic        rot_start;
    logic [1:0]  rot_act;
    logic        rot_busy;
    logic        rot_done;
    logic        rot_end;
    logic        ramp_off;
    logic        link_drop;
    logic        mute_ch1;
    srt_sample_t dp_in;
    srt_sample_t dp_out;
    modport seq (input rot_start, rot_act,
                 output rot_busy, rot_done, rot_end, ramp_off, link_drop);
    modport gate (input mute_ch1, dp_in, output dp_out);
endinterface

/* design/srt_map.svh */
// Register map, field positions, reset values and timing counts
`ifndef SRT_MAP_SVH
`define SRT_MAP_SVH

// ==========================================
// Register offsets
`define SRT_OFS_MODE      12'h03A
`define SRT_OFS_REALIGN   12'h03B
`define SRT_OFS_TXGATE    12'h03F
`define SRT_OFS_OSCSYNC   12'h1E7

// ==========================================
// Field positions
`define SRT_BIT_ROT_DONE  4
`define SRT_BIT_ONESHOT   1
`define SRT_BIT_SYNC_KEEP 7
`define SRT_BIT_PERIODIC  5
`define SRT_BIT_OSC_CLR   4
`define SRT_BIT_ACT_HI    1
`define SRT_BIT_ACT_LO    0
`define SRT_BIT_MUTE1     5
`define SRT_BIT_TRIG      0

// ==========================================
// Reset values and writable-bit masks
`define SRT_RST_MODE      8'h00
`define SRT_RST_REALIGN   8'hB0
`define SRT_RST_TXGATE    8'h00
`define SRT_RST_OSCSYNC   8'h00
`define SRT_WMSK_MODE     8'h03
`define SRT_WMSK_REALIGN  8'hF3
`define SRT_WMSK_TXGATE   8'hE0
`define SRT_WMSK_OSCSYNC  8'h01

// ==========================================
// Timing counts in ref_clk cycles
`define SRT_RAMP_CYC      5'h10
`define SRT_ROT_CYC       5'h08

`endif

/* design/srt_pkg.sv */
// Types shared by the rotation control block
package srt_pkg;
    typedef logic [11:0] srt_addr_t;
    typedef logic [7:0]  srt_byte_t;
    typedef logic [15:0] srt_sample_t;
    typedef logic [4:0]  srt_cnt_t;
    typedef enum logic [1:0] {
        st_idle,
        st_ramp_off,
        st_rotate,
        st_ramp_on
    } srt_state_t;
endpackage

/* design/srt_rot_ctl.sv */
// Top: registers, alignment arming, oscillator clear and datapath gate
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "srt_map.svh"

// Behaviour
// - With clear bit set, NCOs reset after digital reset or rotation; trigger too.
// - Action bit 0 drops links and realigns serial clocks on rotation.
// - Action bit 1 ramps datapath softly off and on around rotation.
// - Action field zero: rotation touches neither links nor datapath; resets zero.
// - Action field 11 performs both link realign and soft off/on.
// - Mute bit set and pin low forces second datapath output to zero.
// - Mute bit set and pin high passes second datapath output normally.
// - Single-shot mode rotates on next edge, then returns to monitor mode.
// - Read-only rotation-complete flag, one after reset.
module srt_rot_ctl import srt_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire srt_addr_t   reg_addr,
    input  wire srt_byte_t   reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      srt_byte_t   reg_rdata,
    input  wire logic        sysref_pin,
    input  wire logic        dig_reset_evt,
    input  wire srt_sample_t dp_ch1_in,
    input  wire logic        transmit_gate_pin_ch1,
    output      srt_sample_t dp_ch1_out,
    output      logic        nco_reset,
    output      logic        serdes_realign,
    output      logic        dp_soft_off,
    output      logic        rotation_done,
    output      logic        periodic_resync_on
);
    srt_ctl_if u_if ();

    srt_byte_t mode_q, mode_d;
    srt_byte_t realign_q, realign_d;
    srt_byte_t txgate_q, txgate_d;
    srt_byte_t oscsync_q, oscsync_d;
    srt_byte_t rdata_q, rdata_d;
    logic      nco_q, nco_d;
    logic      sr_s1_q;
    logic      sr_s2_q;
    logic      sr_s3_q;
    logic      sr_rise;
    logic      wr_mode;
    logic      wr_realign;
    logic      wr_txgate;
    logic      wr_osc;
    logic      rot_start;
    logic      osc_pend;

    // ==========================================
    // Sysref pin synchroniser and edge detect
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sr_s1_q <= 1'b0;
            sr_s2_q <= 1'b0;
            sr_s3_q <= 1'b0;
        end else begin
            sr_s1_q <= sysref_pin;
            sr_s2_q <= sr_s1_q;
            sr_s3_q <= sr_s2_q;
        end
    end

    assign sr_rise = sr_s2_q && !sr_s3_q;

    // ==========================================
    // Write decode
    assign wr_mode    = reg_wr && (reg_addr == `SRT_OFS_MODE);
    assign wr_realign = reg_wr && (reg_addr == `SRT_OFS_REALIGN);
    assign wr_txgate  = reg_wr && (reg_addr == `SRT_OFS_TXGATE);
    assign wr_osc     = reg_wr && (reg_addr == `SRT_OFS_OSCSYNC);

    // An edge that lands mid-rotation is not queued; the sync logic must be kept on
    assign rot_start = sr_rise && mode_q[`SRT_BIT_ONESHOT]
                       && realign_q[`SRT_BIT_SYNC_KEEP] && !u_if.rot_busy;

    // Trigger fires only on a 0 to 1 write of the trigger bit
    assign osc_pend = wr_osc && reg_wdata[`SRT_BIT_TRIG] && !oscsync_q[`SRT_BIT_TRIG];

    // ==========================================
    // Register next values
    always_comb begin
        mode_d    = mode_q;
        realign_d = realign_q;
        txgate_d  = txgate_q;
        oscsync_d = oscsync_q;
        // Fall back to monitor mode once the single rotation is taken
        if (rot_start) begin
            mode_d[`SRT_BIT_ONESHOT] = 1'b0;
        end
        // Software write wins so a re-arm in the same cycle is kept
        if (wr_mode) begin
            mode_d = (mode_q & ~`SRT_WMSK_MODE) | (reg_wdata & `SRT_WMSK_MODE);
        end
        if (wr_realign) begin
            realign_d = (realign_q & ~`SRT_WMSK_REALIGN) | (reg_wdata & `SRT_WMSK_REALIGN);
        end
        if (wr_txgate) begin
            txgate_d = (txgate_q & ~`SRT_WMSK_TXGATE) | (reg_wdata & `SRT_WMSK_TXGATE);
        end
        if (wr_osc) begin
            oscsync_d = reg_wdata & `SRT_WMSK_OSCSYNC;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q    <= `SRT_RST_MODE;
            realign_q <= `SRT_RST_REALIGN;
            txgate_q  <= `SRT_RST_TXGATE;
            oscsync_q <= `SRT_RST_OSCSYNC;
        end else begin
            mode_q    <= mode_d;
            realign_q <= realign_d;
            txgate_q  <= txgate_d;
            oscsync_q <= oscsync_d;
        end
    end

    // ==========================================
    // Oscillator clear pulse
    always_comb begin
        nco_d = osc_pend;
        if (realign_q[`SRT_BIT_OSC_CLR] && (u_if.rot_end || dig_reset_evt)) begin
            nco_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nco_q <= 1'b0;
        end else begin
            nco_q <= nco_d;
        end
    end

    // ==========================================
    // Read path; data stand for one cycle only, unmapped reads give zero
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `SRT_OFS_MODE: begin
                    rdata_d = mode_q & `SRT_WMSK_MODE;
                    rdata_d[`SRT_BIT_ROT_DONE] = u_if.rot_done;
                end
                `SRT_OFS_REALIGN: rdata_d = realign_q;
                `SRT_OFS_TXGATE:  rdata_d = txgate_q;
                `SRT_OFS_OSCSYNC: rdata_d = oscsync_q;
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================
    // Sequencer and transmit gate
    assign u_if.rot_start = rot_start;
    assign u_if.rot_act   = realign_q[`SRT_BIT_ACT_HI:`SRT_BIT_ACT_LO];
    assign u_if.mute_ch1  = txgate_q[`SRT_BIT_MUTE1];
    assign u_if.dp_in     = dp_ch1_in;

    srt_rot_seq u_seq (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ctl     (u_if.seq)
    );

    srt_tx_gate u_gate (
        .ref_clk               (ref_clk),
        .rst                   (rst),
        .transmit_gate_pin_ch1 (transmit_gate_pin_ch1),
        .ctl                   (u_if.gate)
    );

    // ==========================================
    // Outputs, all from flip-flops
    assign reg_rdata          = rdata_q;
    assign dp_ch1_out         = u_if.dp_out;
    assign nco_reset          = nco_q;
    assign serdes_realign     = u_if.link_drop;
    assign dp_soft_off        = u_if.ramp_off;
    assign rotation_done      = u_if.rot_done;
    assign periodic_resync_on = realign_q[`SRT_BIT_PERIODIC];

    // ==========================================
    // Checks
    property p_nco_rot;
        @(posedge ref_clk) disable iff (rst)
        u_if.rot_end && realign_q[`SRT_BIT_OSC_CLR] |=> nco_reset;
    endproperty
    a_nco_rot: assert property (p_nco_rot) else $error("no NCO clear after rotation");

    property p_nco_dig;
        @(posedge ref_clk) disable iff (rst)
        dig_reset_evt && realign_q[`SRT_BIT_OSC_CLR] |=> nco_reset;
    endproperty
    a_nco_dig: assert property (p_nco_dig) else $error("no NCO clear after reset");

    property p_nco_cause;
        @(posedge ref_clk) disable iff (rst)
        nco_reset |-> $past(osc_pend)
                      || ($past(realign_q[`SRT_BIT_OSC_CLR]) && ($past(u_if.rot_end) || $past(dig_reset_evt)));
    endproperty
    a_nco_cause: assert property (p_nco_cause) else $error("NCO clear without cause");

    property p_drop_only;
        @(posedge ref_clk) disable iff (rst)
        rot_start && u_if.rot_act == 2'b01 |=> serdes_realign [*8] ##1 !serdes_realign;
    endproperty
    a_drop_only: assert property (p_drop_only) else $error("link realign wrong length");

    property p_ramp_len;
        @(posedge ref_clk) disable iff (rst)
        $rose(dp_soft_off) |-> ##23 dp_soft_off ##1 !dp_soft_off;
    endproperty
    a_ramp_len: assert property (p_ramp_len) else $error("soft off wrong length");

    property p_no_action;
        @(posedge ref_clk) disable iff (rst)
        rot_start && u_if.rot_act == 2'b00
        |=> (!dp_soft_off && !serdes_realign) [*8] ##1 rotation_done;
    endproperty
    a_no_action: assert property (p_no_action) else $error("action taken with field zero");

    property p_both;
        @(posedge ref_clk) disable iff (rst)
        rot_start && u_if.rot_act == 2'b11 |=> dp_soft_off ##16 (dp_soft_off && serdes_realign);
    endproperty
    a_both: assert property (p_both) else $error("combined action missing");

    property p_oneshot;
        @(posedge ref_clk) disable iff (rst)
        rot_start && !wr_mode |=> !mode_q[`SRT_BIT_ONESHOT] && !rotation_done;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("single shot not retired");

    property p_done_rd;
        @(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `SRT_OFS_MODE |=> reg_rdata[`SRT_BIT_ROT_DONE] == $past(rotation_done);
    endproperty
    a_done_rd: assert property (p_done_rd) else $error("done flag read wrong");

    // Action outputs belong to a rotation; a stray level would upset links or gain
    property p_link_busy;
        @(posedge ref_clk) disable iff (rst)
        serdes_realign |-> u_if.rot_busy;
    endproperty
    a_link_busy: assert property (p_link_busy) else $error("link realign outside rotation");

    property p_soft_busy;
        @(posedge ref_clk) disable iff (rst)
        dp_soft_off |-> u_if.rot_busy;
    endproperty
    a_soft_busy: assert property (p_soft_busy) else $error("soft off outside rotation");

    // Ramp alone must leave the links up in the first cycle of the rotate stage
    property p_ramp_only;
        @(posedge ref_clk) disable iff (rst)
        rot_start && u_if.rot_act == 2'b10 |=> dp_soft_off ##16 (dp_soft_off && !serdes_realign);
    endproperty
    a_ramp_only: assert property (p_ramp_only) else $error("links dropped without bit 0");

    // Monitor mode only watches edges; an unarmed edge must leave every action output quiet
    property p_monitor_quiet;
        @(posedge ref_clk) disable iff (rst)
        sr_rise && !mode_q[`SRT_BIT_ONESHOT] && !u_if.rot_busy
        |=> rotation_done && !dp_soft_off && !serdes_realign;
    endproperty
    a_monitor_quiet: assert property (p_monitor_quiet) else $error("rotation taken in monitor mode");

    // Done may only return as the sequencer leaves its last stage
    property p_done_rise;
        @(posedge ref_clk) disable iff (rst)
        $rose(rotation_done) |-> $past(u_if.rot_busy) && !u_if.rot_busy;
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("done flag raised mid rotation");

    property p_osc_trig;
        @(posedge ref_clk) disable iff (rst)
        osc_pend |=> nco_reset;
    endproperty
    a_osc_trig: assert property (p_osc_trig) else $error("no NCO clear on trigger");

    // Main scenarios
    c_full: cover property (@(posedge ref_clk) disable iff (rst)
        rot_start && u_if.rot_act == 2'b11);
    c_nco: cover property (@(posedge ref_clk) disable iff (rst)
        u_if.rot_end && nco_d);
    c_mute: cover property (@(posedge ref_clk) disable iff (rst)
        u_if.mute_ch1 && dp_ch1_out == 16'h0000 && dp_ch1_in != 16'h0000);
    c_link: cover property (@(posedge ref_clk) disable iff (rst)
        rot_start && u_if.rot_act == 2'b01);
    c_dig: cover property (@(posedge ref_clk) disable iff (rst)
        dig_reset_evt && nco_d);
endmodule

/* design/srt_rot_seq.sv */
// Rotation sequencer: soft ramp off, link realign, ramp on
`timescale 1ns/100ps
`include "srt_map.svh"
module srt_rot_seq import srt_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    srt_ctl_if.seq   ctl
);
    srt_state_t state_q, state_d;
    srt_cnt_t   cnt_q, cnt_d;
    logic [1:0] act_q, act_d;
    logic       done_q, done_d;
    logic       end_q, end_d;
    logic       ramp_q, ramp_d;
    logic       drop_q, drop_d;

    // ==========================================
    // Next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        act_d   = act_q;
        done_d  = done_q;
        end_d   = 1'b0;
        ramp_d  = ramp_q;
        drop_d  = drop_q;
        case (state_q)
            st_idle: begin
                if (ctl.rot_start) begin
                    act_d  = ctl.rot_act;
                    done_d = 1'b0;
                    if (ctl.rot_act[1]) begin
                        state_d = st_ramp_off;
                        cnt_d   = `SRT_RAMP_CYC - 5'h01;
                        ramp_d  = 1'b1;
                    end else begin
                        state_d = st_rotate;
                        cnt_d   = `SRT_ROT_CYC - 5'h01;
                        drop_d  = ctl.rot_act[0];
                    end
                end
            end
            st_ramp_off: begin
                if (cnt_q == 5'h00) begin
                    state_d = st_rotate;
                    cnt_d   = `SRT_ROT_CYC - 5'h01;
                    drop_d  = act_q[0];
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            st_rotate: begin
                if (cnt_q == 5'h00) begin
                    drop_d = 1'b0;
                    end_d  = 1'b1;
                    if (act_q[1]) begin
                        state_d = st_ramp_on;
                        cnt_d   = `SRT_RAMP_CYC - 5'h01;
                        ramp_d  = 1'b0;
                    end else begin
                        state_d = st_idle;
                        done_d  = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            st_ramp_on: begin
                // Wait for the gain ramp to settle before reporting done
                if (cnt_q == 5'h00) begin
                    state_d = st_idle;
                    done_d  = 1'b1;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            default: state_d = st_idle;
        endcase
    end

    // ==========================================
    // State registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= st_idle;
            cnt_q   <= 5'h00;
            act_q   <= 2'h0;
            done_q  <= 1'b1;
            end_q   <= 1'b0;
            ramp_q  <= 1'b0;
            drop_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            act_q   <= act_d;
            done_q  <= done_d;
            end_q   <= end_d;
            ramp_q  <= ramp_d;
            drop_q  <= drop_d;
        end
    end

    assign ctl.rot_busy  = (state_q != st_idle);
    assign ctl.rot_done  = done_q;
    assign ctl.rot_end   = end_q;
    assign ctl.ramp_off  = ramp_q;
    assign ctl.link_drop = drop_q;
endmodule

/* design/srt_tx_gate.sv */
// Transmit gate: zeroes the second datapath while its mute bit is set and its pin is low
`timescale 1ns/100ps
`include "srt_map.svh"
module srt_tx_gate import srt_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic transmit_gate_pin_ch1,
    srt_ctl_if.gate  ctl
);
    logic        pin_s1_q;
    logic        pin_s2_q;
    srt_sample_t out_q, out_d;

    // ==========================================
    // Output select; the pin is synchronised first, so gating lags it by two cycles
    always_comb begin
        out_d = ctl.dp_in;
        if (ctl.mute_ch1 && !pin_s2_q) begin
            out_d = 16'h0000;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            out_q    <= 16'h0000;
        end else begin
            pin_s1_q <= transmit_gate_pin_ch1;
            pin_s2_q <= pin_s1_q;
            out_q    <= out_d;
        end
    end

    assign ctl.dp_out = out_q;

    // ==========================================
    // Checks
    property p_mute_zero;
        @(posedge ref_clk) disable iff (rst)
        ctl.mute_ch1 && !pin_s2_q |=> out_q == 16'h0000;
    endproperty
    a_mute_zero: assert property (p_mute_zero) else $error("muted output not zero");

    property p_pass;
        @(posedge ref_clk) disable iff (rst)
        pin_s2_q || !ctl.mute_ch1 |=> out_q == $past(ctl.dp_in);
    endproperty
    a_pass: assert property (p_pass) else $error("enabled output not passed");
endmodule

/* verification/test_srt_rot_ctl.sv */
// Self-checking bench for the rotation control block
`timescale 1ns/100ps
`include "srt_map.svh"

// One comparison: counts it, prints and counts a mismatch
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module test_srt_rot_ctl import srt_pkg::*;;
    logic        ref_clk;
    logic        rst;
    srt_addr_t   reg_addr;
    srt_byte_t   reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    srt_byte_t   reg_rdata;
    logic        sysref_pin;
    logic        dig_reset_evt;
    srt_sample_t dp_ch1_in;
    logic        transmit_gate_pin_ch1;
    srt_sample_t dp_ch1_out;
    logic        nco_reset;
    logic        serdes_realign;
    logic        dp_soft_off;
    logic        rotation_done;
    logic        periodic_resync_on;
    int          err_total;
    int          num_checks;
    int          cyc;

    srt_rot_ctl u_srt_rot_ctl (
        .ref_clk               (ref_clk),
        .rst                   (rst),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .sysref_pin            (sysref_pin),
        .dig_reset_evt         (dig_reset_evt),
        .dp_ch1_in             (dp_ch1_in),
        .transmit_gate_pin_ch1 (transmit_gate_pin_ch1),
        .dp_ch1_out            (dp_ch1_out),
        .nco_reset             (nco_reset),
        .serdes_realign        (serdes_realign),
        .dp_soft_off           (dp_soft_off),
        .rotation_done         (rotation_done),
        .periodic_resync_on    (periodic_resync_on)
    );

    // ==========================================
    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;

    // Whole run is a few hundred cycles; the ceiling leaves ample slack
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    // ==========================================
    // Bus and observation helpers
    task automatic wr(input srt_addr_t a, input srt_byte_t d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input srt_addr_t a, output srt_byte_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Counts high cycles of NCO clear, link realign and soft off, and low cycles of done, over a window
    task automatic watch(input int n, output int c_nco, output int c_lnk, output int c_off, output int c_busy);
        c_nco = 0;
        c_lnk = 0;
        c_off = 0;
        c_busy = 0;
        repeat (n) begin
            #1;
            `CHK("known", 1'b0, $isunknown({nco_reset, serdes_realign, dp_soft_off, rotation_done}))
            c_nco += (nco_reset === 1'b1);
            c_lnk += (serdes_realign === 1'b1);
            c_off += (dp_soft_off === 1'b1);
            c_busy += (rotation_done === 1'b0);
            @(posedge ref_clk);
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset_regs();
        srt_byte_t v;
        `CHK("resync_out", 1'b1, periodic_resync_on)
        `CHK("done_out", 1'b1, rotation_done)
        rd(`SRT_OFS_MODE, v);    `CHK("mode_rst", 8'h10, v)
        #10 `CHK("rdata_idle", 8'h00, reg_rdata)
        rd(`SRT_OFS_REALIGN, v); `CHK("realign_rst", 8'hB0, v)
        rd(`SRT_OFS_TXGATE, v);  `CHK("txgate_rst", 8'h00, v)
        rd(`SRT_OFS_OSCSYNC, v); `CHK("osc_rst", 8'h00, v)
        wr(12'h100, 8'hFF);
        rd(12'h100, v);          `CHK("unmapped", 8'h00, v)
        wr(`SRT_OFS_REALIGN, 8'hFF);
        rd(`SRT_OFS_REALIGN, v); `CHK("realign_ro", 8'hF3, v)
        wr(`SRT_OFS_REALIGN, 8'hD3);
        #1 `CHK("resync_off", 1'b0, periodic_resync_on)
        wr(`SRT_OFS_TXGATE, 8'hFF);
        rd(`SRT_OFS_TXGATE, v);  `CHK("txgate_ro", 8'hE0, v)
        wr(`SRT_OFS_MODE, 8'hFF);
        rd(`SRT_OFS_MODE, v);    `CHK("mode_ro", 8'h13, v)
        wr(`SRT_OFS_MODE, 8'h00);
    endtask

    // Arms single-shot, fires one edge, then checks a second edge is ignored
    task automatic t_rotate(input logic [1:0] act, input logic clr, input int e_lnk, input int e_off,
                            input int e_busy);
        srt_byte_t v;
        int        a, b, c, d;
        wr(`SRT_OFS_REALIGN, {3'b111, clr, 2'b00, act});
        wr(`SRT_OFS_MODE, 8'h02);
        rd(`SRT_OFS_MODE, v);    `CHK("armed", 8'h12, v)
        @(posedge ref_clk);
        sysref_pin <= 1'b1;
        watch(70, a, b, c, d);
        `CHK("nco_pulses", int'(clr), a)
        `CHK("link_cycles", e_lnk, b)
        `CHK("ramp_cycles", e_off, c)
        `CHK("busy_cycles", e_busy, d)
        sysref_pin <= 1'b0;
        rd(`SRT_OFS_MODE, v);    `CHK("monitor", 8'h10, v)
        @(posedge ref_clk);
        sysref_pin <= 1'b1;
        watch(20, a, b, c, d);
        `CHK("no_second", 0, a + b + c + d)
        sysref_pin <= 1'b0;
    endtask

    // Trigger bit pulses only on a 0 to 1 write; digital reset obeys the clear bit
    task automatic t_osc();
        int a, b, c, d;
        wr(`SRT_OFS_OSCSYNC, 8'h01); watch(5, a, b, c, d); `CHK("trig_rise", 1, a)
        wr(`SRT_OFS_OSCSYNC, 8'h01); watch(5, a, b, c, d); `CHK("trig_hold", 0, a)
        wr(`SRT_OFS_OSCSYNC, 8'h00); watch(5, a, b, c, d); `CHK("trig_low", 0, a)
        wr(`SRT_OFS_OSCSYNC, 8'h01); watch(5, a, b, c, d); `CHK("trig_rearm", 1, a)
        for (int i = 0; i < 2; i++) begin
            wr(`SRT_OFS_REALIGN, i ? 8'hE1 : 8'hF1);
            @(posedge ref_clk);
            dig_reset_evt <= 1'b1;
            @(posedge ref_clk);
            dig_reset_evt <= 1'b0;
            watch(5, a, b, c, d);
            `CHK("dig_reset_clr", 1 - i, a)
        end
    endtask

    // Mute only while the bit is set and the pin is low; pin is synchronised first
    task automatic t_gate();
        logic [2:0] tbl [4] = '{3'b000, 3'b100, 3'b110, 3'b010};
        for (int i = 0; i < 4; i++) begin
            wr(`SRT_OFS_TXGATE, tbl[i][2] ? 8'h20 : 8'h00);
            @(posedge ref_clk);
            transmit_gate_pin_ch1 <= tbl[i][1];
            dp_ch1_in             <= 16'hA5C3 ^ 16'(i);
            repeat (6) @(posedge ref_clk);
            #1 `CHK("gate_out", (tbl[i][2] && !tbl[i][1]) ? 16'h0000 : (16'hA5C3 ^ 16'(i)), dp_ch1_out)
        end
    endtask

    // ==========================================
    // Verdict
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sysref_pin = 1'b0;
        dig_reset_evt = 1'b0;
        dp_ch1_in = 16'h1234;
        transmit_gate_pin_ch1 = 1'b1;
        err_total = 0;
        num_checks = 0;
        cyc = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1 `CHK("dp_out_rst", 16'h0000, dp_ch1_out)
        t_reset_regs();
        t_rotate(2'b00, 1'b1, 0, 0, 8);
        t_rotate(2'b01, 1'b0, 8, 0, 8);
        t_rotate(2'b10, 1'b1, 0, 24, 40);
        t_rotate(2'b11, 1'b1, 8, 24, 40);
        t_osc();
        t_gate();
        summarize();
    end
endmodule
